// [bench/ata_host_model.sv]
// Host controller model issuing task-file accesses over AXI4-Lite
`timescale 1ns/10ps
module ata_host_model (
	// Clock
	input wire logic clk,
	// Write channels
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// Read channels
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready,
	// Set once an answer never came
	output logic hung
);
	// Idle bus at time zero
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready, hung} = '0;
	end

	// one write, address and data offered together, each released once taken
	task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		rsp = bresp;
		bready <= 1'b0;
		if (n == 64)
			hung = 1'b1;
	endtask : write

	// One read; rready held until the data is seen
	task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		d = rdata;
		rsp = rresp;
		rready <= 1'b0;
		if (n == 64)
			hung = 1'b1;
	endtask : read
endmodule : ata_host_model

// [bench/ata_security_and_set_features_cmds_tb.sv]
// Self-checking bench for the security and set-features engine
`timescale 1ns/10ps
module ata_security_and_set_features_cmds_tb
	import ata_sec_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic softReset = 1'b0;
	logic nvInit = 1'b0;
	logic cacheFlushDone = 1'b0;
	logic cacheFlushReq, sixteenBitIoIndicator, eraseUnitAllowed, deviceLocked, hung;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rv;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp;
	cfg_t cfgOut, expCfg;
	int error_cnt = 0;
	int comparisons = 0;
	int flushCnt = 0;
	int attempts, locked, maxLvl, userPwd, masterPwd, expErr, n;
	int armed = 0;
	logic [15:0] tbl [$] = '{16'h0100, 16'h8100, 16'h0200, 16'h5500, 16'haa00, 16'h6600,
		16'hcc00, 16'h6900, 16'h9600, 16'h9700, 16'hbb00, 16'h0580, 16'h8500, 16'h0900,
		16'h8900, 16'h0a00, 16'h8a00, 16'h9a06, 16'h9aff, 16'h9a00, 16'h0342, 16'h0321,
		16'h0301, 16'h030b, 16'h0310, 16'h3c00};

	always #2 clk = ~clk;

	// Media side answers a flush slowly, so busy is seen standing
	always @(posedge clk) begin
		flushCnt <= cacheFlushReq ? flushCnt + 1 : 0;
		cacheFlushDone <= (flushCnt == 20);
	end

	ata_sec_engine dut_u (.clk(clk), .rst(rst), .softReset(softReset), .nvInit(nvInit),
		.cacheFlushDone(cacheFlushDone), .cacheFlushReq(cacheFlushReq),
		.sixteenBitIoIndicator(sixteenBitIoIndicator), .eraseUnitAllowed(eraseUnitAllowed),
		.deviceLocked(deviceLocked), .cfgOut(cfgOut), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	ata_host_model host_u (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.hung(hung));

	task automatic finish_test;
		$display("Mismatches %0d, comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	// Bus wrappers; a hung bus ends the run
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host_u.write(a, d, rsp);
		if (hung) begin
			error_cnt++;
			finish_test();
		end
	endtask : wr

	task automatic rd(input logic [7:0] a);
		host_u.read(a, rv, rsp);
		if (hung) begin
			error_cnt++;
			finish_test();
		end
	endtask : rd

	task automatic do_reset;
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		expCfg = CFG_DEFAULT;
		attempts = 5;
		locked = armed;
	endtask : do_reset

	task automatic chk_st(input int errKnown);
		rd(ADDR_STATUS);
		check(rv[10:8], attempts[2:0]);
		check(rv[3], locked[0]);
		check(deviceLocked, locked[0]);
		check(eraseUnitAllowed, attempts != 0);
		check(rv[1:0], 2'b00);
		check(rv[4], armed[0]);
		check(rv[5], maxLvl[0]);
		check(rv[6], attempts == 0);
		check(rsp, RESP_OKAY);
		if (errKnown != 0)
			check(rv[2], expErr[0]);
	endtask : chk_st

	// Command plus one whole sector; reserved words carry random data
	task automatic sector(input logic [7:0] cmd, input logic id, input logic lvl, input int pwd);
		wr(ADDR_CMD, {24'h0, cmd});
		wr(ADDR_DATA, {16'h0, 7'h0, lvl, 7'h0, id});
		for (int i = 1; i < 256; i++)
			wr(ADDR_DATA, {16'h0, (i <= 16) ? 16'(pwd ^ i) : 16'($urandom)});
	endtask : sector

	// password store follows identifier and level
	task automatic setpwd(input logic id, input logic lvl, input int pwd);
		sector(CMD_SET_PWD, id, lvl, pwd);
		if (id) begin
			masterPwd = pwd;
		end else begin
			userPwd = pwd;
			maxLvl = lvl;
			armed = 1;
		end
		expErr = 0;
		chk_st(1);
	endtask : setpwd

	// unlock model: master only at high level, counter on locked mismatch
	task automatic unlock(input logic id, input int pwd);
		int known;
		sector(CMD_UNLOCK, id, 1'b0, pwd);
		known = (locked != 0 || attempts == 0);
		expErr = 1;
		if (attempts != 0 && locked != 0) begin
			if (id ? (maxLvl == 0 && pwd == masterPwd) : pwd == userPwd) begin
				locked = 0;
				expErr = 0;
			end else if (!(id && maxLvl != 0 && pwd == masterPwd)) begin
				attempts--;
			end
		end
		chk_st(known);
	endtask : unlock

	// set-features model then compare configuration and abort flag
	task automatic feat(input logic [7:0] f, input logic [7:0] c);
		expErr = 0;
		case (f)
			FT_8BIT_ON: expCfg.eightBit = 1'b1;
			FT_8BIT_OFF: expCfg.eightBit = 1'b0;
			FT_WC_ON: expCfg.writeCache = 1'b1;
			FT_RLA_OFF: expCfg.lookAhead = 1'b0;
			FT_RLA_ON: expCfg.lookAhead = 1'b1;
			FT_POR_OFF: expCfg.porDefaults = 1'b0;
			FT_POR_ON: expCfg.porDefaults = 1'b1;
			FT_APM_ON: begin
				expCfg.apmEn = 1'b1;
				expCfg.apmLevel = c;
			end
			FT_APM_OFF: expCfg.apmEn = 1'b0;
			FT_EXTPWR_ON: expCfg.extPower = 1'b1;
			FT_EXTPWR_OFF: expCfg.extPower = 1'b0;
			FT_PL1_ON: expCfg.powerLevel1 = 1'b1;
			FT_PL1_OFF: expCfg.powerLevel1 = 1'b0;
			FT_LONG4: expCfg.longExtra = 1'b1;
			FT_CURRENT: expCfg.currentCap = (c < CUR_MIN) ? CUR_MIN : (c > CUR_MAX) ? CUR_MAX : c;
			FT_NOP_A, FT_NOP_B, FT_NOP_C: ;
			FT_XFER_MODE: begin
				case (c[7:3])
					XT_PIO_DEF: begin
						expCfg.pioMode = 3'h0;
						expCfg.iordyOff = (c[2:0] == MODE_NO_IORDY);
					end
					XT_PIO_FC: begin
						expCfg.pioMode = c[2:0];
						expCfg.iordyOff = 1'b0;
					end
					XT_MDMA, XT_UDMA: begin
						expCfg.dmaUltra = (c[7:3] == XT_UDMA);
						expCfg.dmaMode = c[2:0];
					end
					default: expErr = 1;
				endcase
			end
			default: expErr = 1;
		endcase
		wr(ADDR_TASK, {16'h0, c, f});
		wr(ADDR_CMD, {24'h0, CMD_SET_FEAT});
		check(rsp, RESP_OKAY);
		rd(ADDR_CFG);
		check(rsp, RESP_OKAY);
		check(rv, 32'(expCfg));
		check(cfgOut, expCfg);
		check(sixteenBitIoIndicator, !expCfg.eightBit);
		rd(ADDR_STATUS);
		check(rv[2], expErr[0]);
	endtask : feat

	task automatic pulse_soft;
		softReset <= 1'b1;
		@(posedge clk);
		softReset <= 1'b0;
	endtask : pulse_soft

	initial begin
		void'($urandom(52));
		do_reset();
		nvInit <= 1'b1;
		@(posedge clk);
		nvInit <= 1'b0;
		do_reset();
		chk_st(0);
		// Refused places on the bus
		wr(ADDR_CFG, 32'h0);
		check(rsp, RESP_SLVERR);
		rd(8'h40);
		check(rsp, RESP_SLVERR);
		check(rv, 32'h0);
		// Supported current range is reported back to the host
		rd(ADDR_CURRENT);
		check(rv, {16'h0, CUR_MAX, CUR_MIN});
		// A command code outside the handled set is aborted
		expErr = 1;
		wr(ADDR_CMD, {24'h0, 8'h3c});
		chk_st(1);
		// 8-bit mode cleared again before any DMA mode is chosen
		foreach (tbl[i])
			feat(tbl[i][15:8], (tbl[i][7:0] == 8'h00) ? 8'($urandom) : tbl[i][7:0]);
		// flush holds busy; a command meanwhile is ignored
		wr(ADDR_TASK, {16'h0, 8'h00, FT_WC_OFF});
		wr(ADDR_CMD, {24'h0, CMD_SET_FEAT});
		expCfg.writeCache = 1'b0;
		check(cacheFlushReq, 1'b1);
		// Look-ahead is on here, so an accepted disable would show in the next compare
		wr(ADDR_TASK, {16'h0, 8'h00, FT_RLA_OFF});
		wr(ADDR_CMD, {24'h0, CMD_SET_FEAT});
		rd(ADDR_STATUS);
		check(rv[0], 1'b1);
		for (n = 0; n < 100 && rv[0] !== 1'b0; n++)
			rd(ADDR_STATUS);
		check(rv[0], 1'b0);
		if (rv[0] !== 1'b0)
			finish_test();
		check(cacheFlushReq, 1'b0);
		feat(FT_NOP_C, 8'($urandom));
		feat(FT_WC_ON, 8'($urandom));
		// soft reset restores defaults only when enabled
		feat(FT_POR_OFF, 8'h00);
		pulse_soft();
		feat(FT_NOP_A, 8'h00);
		feat(FT_POR_ON, 8'h00);
		pulse_soft();
		expCfg = CFG_DEFAULT;
		feat(FT_NOP_B, 8'h00);
		// master set, then user at high level armed for next reset
		setpwd(1'b1, 1'b0, 32'h1111);
		setpwd(1'b0, 1'b0, 32'h2222);
		do_reset();
		chk_st(0);
		unlock(1'b0, 32'h3333);
		unlock(1'b1, 32'h1111);
		unlock(1'b0, 32'h3333);
		// maximum level refuses master, counter runs out
		setpwd(1'b0, 1'b1, 32'h2222);
		do_reset();
		unlock(1'b1, 32'h1111);
		repeat (5)
			unlock(1'b0, 32'h4444);
		unlock(1'b0, 32'h2222);
		do_reset();
		unlock(1'b0, 32'h2222);
		finish_test();
	end
endmodule : ata_security_and_set_features_cmds_tb

// [rtl/ata_sec_engine.sv]
// Security password and set-features command engine behind an AXI4-Lite slave
// Operation
// - Password commands take exactly one 256-word sector
// - Word0 bit0 identifier, bit8 level, words1-16 password
// - User at high level: master also unlocks
// - User at maximum level: only user unlocks
// - Master identifier stores master password only
// - Unlock with master at high compares master
// - Maximum level rejects master unlock attempts
// - Failed user unlock aborts and decrements counter
// - Counter starts at five, counts locked mismatches
// - Counter zero aborts unlock and erase unit
// - Unlock while unlocked leaves counter alone
// - Features register picks subcommand; 03h sets mode
// - 8-bit mode uses low byte, no 16-bit indicator (data port still needs both byte lanes)
// - Cache disable flushes before completion
// - 55h disables, AAh enables read look-ahead
// - 66h/CCh control defaults restore at soft reset
// - 69h, 96h, 97h complete with no effect
// - BBh adds four bytes to long commands
// - Power management, extended power, current capability
// - Sector count splits into type and mode
// - Exactly one PIO and one DMA mode held
// - Type codes PIO, flow PIO, multiword, ultra
// - Ultra and multiword DMA exclude each other
`timescale 1ns/10ps
module ata_sec_engine
	import ata_sec_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Card events
	input wire logic softReset,
	input wire logic nvInit,
	input wire logic cacheFlushDone,
	// Card state
	output logic cacheFlushReq,
	output logic sixteenBitIoIndicator,
	output logic eraseUnitAllowed,
	output logic deviceLocked,
	output cfg_t cfgOut,
	// AXI4-Lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	logic awHave_reg, wHave_reg;
	logic [7:0] awAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	logic [7:0] taskFeat_reg, taskCount_reg;
	state_t state_reg;
	logic [7:0] cmd_reg, wordCnt_reg;
	logic idMaster_reg, levelMax_reg, match_reg;
	logic secEnabled_reg, secMax_reg, locked_reg, err_reg;
	logic [2:0] attempts_reg;
	cfg_t cfg_reg, featCfg;
	logic featAbort, featFlush;
	logic [15:0] pwdUser [16];
	logic [15:0] pwdMaster [16];

	// Write address decode, done once both halves are held
	wire doWrite = awHave_reg && wHave_reg && !bvalid;
	wire hitTask = awAddr_reg == ADDR_TASK;
	wire hitCmd = awAddr_reg == ADDR_CMD;
	wire hitData = awAddr_reg == ADDR_DATA;
	wire writeOk = hitTask || hitCmd || hitData;
	wire [7:0] cmdCode = wData_reg[7:0];
	wire startCmd = doWrite && hitCmd && wStrb_reg[0] && state_reg == ST_IDLE;
	wire featCmd = startCmd && cmdCode == CMD_SET_FEAT;
	wire pwdCmd = startCmd && (cmdCode == CMD_SET_PWD || cmdCode == CMD_UNLOCK);
	wire otherCmd = startCmd && !featCmd && !pwdCmd;
	// Data words are only taken while a sector is expected, as whole halfwords
	wire dataWord = doWrite && hitData && &wStrb_reg[1:0] && state_reg == ST_XFER;
	wire [15:0] word = wData_reg[15:0];
	wire inPwd = wordCnt_reg >= PWD_FIRST && wordCnt_reg <= PWD_LAST;
	wire [3:0] pwdIdx = 4'(wordCnt_reg - PWD_FIRST);
	wire lastWord = dataWord && wordCnt_reg == WORD_LAST;
	wire finSet = lastWord && cmd_reg == CMD_SET_PWD;
	wire finUnlock = lastWord && cmd_reg == CMD_UNLOCK;
	wire exhausted = attempts_reg == 3'h0;
	wire [15:0] pwdRef = idMaster_reg ? pwdMaster[pwdIdx] : pwdUser[pwdIdx];
	// Master only counts at high level; maximum level keeps it out entirely
	wire unlockOk = !exhausted && match_reg && !(idMaster_reg && secMax_reg);
	wire countMiss = finUnlock && !match_reg && locked_reg && !exhausted;
	wire [4:0] xferType = taskCount_reg[7:3];
	wire [2:0] xferMode = taskCount_reg[2:0];

	// Read address decode
	wire [31:0] statusWord = {21'h0, attempts_reg, 1'b0, exhausted, secMax_reg,
		secEnabled_reg, locked_reg, err_reg, state_reg == ST_XFER, state_reg != ST_IDLE};
	wire readHit = araddr == ADDR_TASK || araddr == ADDR_STATUS || araddr == ADDR_CFG
		|| araddr == ADDR_CURRENT;
	wire [31:0] readWord = araddr == ADDR_TASK ? {16'h0, taskCount_reg, taskFeat_reg} :
		araddr == ADDR_STATUS ? statusWord :
		araddr == ADDR_CFG ? cfg_reg :
		araddr == ADDR_CURRENT ? {16'h0, CUR_MAX, CUR_MIN} : 32'h0;

	// Write channels: address and data taken in either order
	always_ff @(posedge clk) begin
		if (rst) begin
			awready <= 1'b1;
			wready <= 1'b1;
			awHave_reg <= 1'b0;
			wHave_reg <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				awHave_reg <= 1'b1;
			end else if (doWrite) begin
				awready <= 1'b1;
				awHave_reg <= 1'b0;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				wHave_reg <= 1'b1;
			end else if (doWrite) begin
				wready <= 1'b1;
				wHave_reg <= 1'b0;
			end
			if (doWrite) begin
				bvalid <= 1'b1;
				bresp <= writeOk ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Write payload capture
	always_ff @(posedge clk) begin
		if (awvalid && awready) begin
			awAddr_reg <= awaddr;
		end
		if (wvalid && wready) begin
			wData_reg <= wdata;
			wStrb_reg <= wstrb;
		end
	end

	// Read channel: one cycle from address to data
	always_ff @(posedge clk) begin
		if (rst) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= readWord;
			rresp <= readHit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// Task file registers, byte lanes honoured
	always_ff @(posedge clk) begin
		if (rst) begin
			taskFeat_reg <= 8'h00;
			taskCount_reg <= 8'h00;
		end else if (doWrite && hitTask) begin
			if (wStrb_reg[0]) taskFeat_reg <= wData_reg[7:0];
			if (wStrb_reg[1]) taskCount_reg <= wData_reg[15:8];
		end
	end

	// Subcommand decode; configuration is only committed when not aborted
	always_comb begin
		featCfg = cfg_reg;
		featAbort = 1'b0;
		featFlush = 1'b0;
		case (taskFeat_reg)
			FT_8BIT_ON: featCfg.eightBit = 1'b1;
			FT_8BIT_OFF: featCfg.eightBit = 1'b0;
			FT_WC_ON: featCfg.writeCache = 1'b1;
			FT_WC_OFF: begin
				featCfg.writeCache = 1'b0;
				featFlush = 1'b1;
			end
			FT_XFER_MODE: begin
				case (xferType)
					XT_PIO_DEF: begin
						featCfg.pioMode = 3'h0;
						featCfg.iordyOff = xferMode == MODE_NO_IORDY;
					end
					XT_PIO_FC: begin
						featCfg.pioMode = xferMode;
						featCfg.iordyOff = 1'b0;
					end
					XT_MDMA: begin
						featCfg.dmaUltra = 1'b0;
						featCfg.dmaMode = xferMode;
					end
					XT_UDMA: begin
						featCfg.dmaUltra = 1'b1;
						featCfg.dmaMode = xferMode;
					end
					default: featAbort = 1'b1;
				endcase
			end
			FT_APM_ON: begin
				featCfg.apmEn = 1'b1;
				featCfg.apmLevel = taskCount_reg;
			end
			FT_APM_OFF: featCfg.apmEn = 1'b0;
			FT_EXTPWR_ON: featCfg.extPower = 1'b1;
			FT_EXTPWR_OFF: featCfg.extPower = 1'b0;
			FT_PL1_ON: featCfg.powerLevel1 = 1'b1;
			FT_PL1_OFF: featCfg.powerLevel1 = 1'b0;
			FT_CURRENT: begin
				featCfg.currentCap = taskCount_reg < CUR_MIN ? CUR_MIN :
					taskCount_reg > CUR_MAX ? CUR_MAX : taskCount_reg;
			end
			FT_RLA_OFF: featCfg.lookAhead = 1'b0;
			FT_RLA_ON: featCfg.lookAhead = 1'b1;
			FT_POR_OFF: featCfg.porDefaults = 1'b0;
			FT_POR_ON: featCfg.porDefaults = 1'b1;
			FT_NOP_A, FT_NOP_B, FT_NOP_C: featAbort = 1'b0;
			FT_LONG4: featCfg.longExtra = 1'b1;
			default: featAbort = 1'b1;
		endcase
	end

	// Configuration; a soft reset restores defaults only while that is enabled
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_reg <= CFG_DEFAULT;
		end else if (softReset && cfg_reg.porDefaults) begin
			cfg_reg <= CFG_DEFAULT;
		end else if (featCmd && !featAbort) begin
			cfg_reg <= featCfg;
		end
	end

	// Command sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			cmd_reg <= 8'h00;
			wordCnt_reg <= 8'h00;
			err_reg <= 1'b0;
			cacheFlushReq <= 1'b0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (startCmd) begin
						cmd_reg <= cmdCode;
						wordCnt_reg <= 8'h00;
						err_reg <= otherCmd || (featCmd && featAbort);
					end
					if (pwdCmd) begin
						state_reg <= ST_XFER;
					end else if (featCmd && !featAbort && featFlush) begin
						state_reg <= ST_FLUSH;
						cacheFlushReq <= 1'b1;
					end
				end
				ST_XFER: begin
					if (dataWord) begin
						wordCnt_reg <= wordCnt_reg + 8'h01;
					end
					if (lastWord) begin
						state_reg <= ST_IDLE;
					end
					if (finUnlock && !unlockOk) begin
						err_reg <= 1'b1;
					end
				end
				ST_FLUSH: begin
					if (cacheFlushDone) begin
						cacheFlushReq <= 1'b0;
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Sector control word and running password compare
	always_ff @(posedge clk) begin
		if (rst) begin
			idMaster_reg <= 1'b0;
			levelMax_reg <= 1'b0;
			match_reg <= 1'b0;
		end else if (dataWord && wordCnt_reg == 8'h00) begin
			idMaster_reg <= word[ID_BIT];
			levelMax_reg <= word[LEVEL_BIT];
			match_reg <= 1'b1;
		end else if (dataWord && inPwd && cmd_reg == CMD_UNLOCK) begin
			match_reg <= match_reg && word == pwdRef;
		end
	end

	// Password store; written word by word, it has no reset like a flash array
	always_ff @(posedge clk) begin
		if (dataWord && inPwd && cmd_reg == CMD_SET_PWD) begin
			if (idMaster_reg) pwdMaster[pwdIdx] <= word;
			else pwdUser[pwdIdx] <= word;
		end
	end

	// Non-volatile security state, cleared only by initialisation
	always_ff @(posedge clk) begin
		if (nvInit) begin
			secEnabled_reg <= 1'b0;
			secMax_reg <= 1'b0;
		end else if (finSet && !idMaster_reg) begin
			secEnabled_reg <= 1'b1;
			secMax_reg <= levelMax_reg;
		end
	end

	// Lock and attempt counter; the lock only takes effect at the next reset
	always_ff @(posedge clk) begin
		if (rst) begin
			locked_reg <= secEnabled_reg;
			attempts_reg <= ATTEMPTS_INIT;
		end else begin
			if (finUnlock && unlockOk) begin
				locked_reg <= 1'b0;
			end
			if (countMiss) begin
				attempts_reg <= attempts_reg - 3'h1;
			end
		end
	end

	// Card-side outputs from flip-flops
	always_ff @(posedge clk) begin
		if (rst) begin
			sixteenBitIoIndicator <= 1'b1;
			eraseUnitAllowed <= 1'b1;
			deviceLocked <= 1'b0;
			cfgOut <= CFG_DEFAULT;
		end else begin
			sixteenBitIoIndicator <= !cfg_reg.eightBit;
			eraseUnitAllowed <= !exhausted;
			deviceLocked <= locked_reg;
			cfgOut <= cfg_reg;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence seqSetUserEnd;
		finSet && !idMaster_reg;
	endsequence
	sequence seqMissLocked;
		finUnlock && !match_reg && locked_reg && !exhausted;
	endsequence

	AST_ONE_SECTOR: assert property (lastWord |=> state_reg == ST_IDLE ##1 !dataWord)
		else $error("sector did not end after word 255");
	AST_USER_LEVEL: assert property (seqSetUserEnd |=> secEnabled_reg && secMax_reg == $past(levelMax_reg))
		else $error("user password did not arm level");
	AST_MASTER_KEEPS: assert property (finSet && idMaster_reg |=> $stable(secEnabled_reg) && $stable(secMax_reg))
		else $error("master password changed lock state");
	AST_MAX_REJECT: assert property (finUnlock && idMaster_reg && secMax_reg |=> err_reg && locked_reg == $past(locked_reg))
		else $error("master unlock accepted at maximum level");
	AST_DECREMENT: assert property (seqMissLocked |=> attempts_reg == 3'($past(attempts_reg) - 3'h1) && err_reg)
		else $error("mismatch did not decrement counter");
	AST_EXHAUSTED: assert property (finUnlock && exhausted |=> err_reg && $stable(locked_reg) ##1 !eraseUnitAllowed)
		else $error("unlock taken with counter at zero");
	AST_UNLOCKED_COUNT: assert property (finUnlock && !locked_reg |=> $stable(attempts_reg))
		else $error("counter moved while unlocked");
	AST_UDMA_MODE: assert property (featCmd && taskFeat_reg == FT_XFER_MODE && xferType == XT_UDMA
		|=> cfg_reg.dmaUltra && cfg_reg.dmaMode == $past(xferMode))
		else $error("ultra DMA mode not selected");
	AST_FLUSH_HOLD: assert property (state_reg == ST_FLUSH && !cacheFlushDone |=> state_reg == ST_FLUSH && cacheFlushReq)
		else $error("cache disable completed before flush");
	AST_UNKNOWN_FEAT: assert property (featCmd && featAbort |=> err_reg && $stable(cfg_reg))
		else $error("unknown subcommand changed configuration");
	AST_EIGHT_BIT: assert property (cfg_reg.eightBit |=> !sixteenBitIoIndicator)
		else $error("16-bit indicator asserted in 8-bit mode");
endmodule : ata_sec_engine

// [rtl/ata_sec_pkg.sv]
// Constants and types for the security and set-features command engine
package ata_sec_pkg;
	// Command codes
	localparam logic [7:0] CMD_SET_PWD = 8'hf1;
	localparam logic [7:0] CMD_UNLOCK = 8'hf2;
	localparam logic [7:0] CMD_SET_FEAT = 8'hef;
	// Set-features subcommands
	localparam logic [7:0] FT_8BIT_ON = 8'h01;
	localparam logic [7:0] FT_8BIT_OFF = 8'h81;
	localparam logic [7:0] FT_WC_ON = 8'h02;
	localparam logic [7:0] FT_WC_OFF = 8'h82;
	localparam logic [7:0] FT_XFER_MODE = 8'h03;
	localparam logic [7:0] FT_APM_ON = 8'h05;
	localparam logic [7:0] FT_APM_OFF = 8'h85;
	localparam logic [7:0] FT_EXTPWR_ON = 8'h09;
	localparam logic [7:0] FT_EXTPWR_OFF = 8'h89;
	localparam logic [7:0] FT_PL1_ON = 8'h0a;
	localparam logic [7:0] FT_PL1_OFF = 8'h8a;
	localparam logic [7:0] FT_RLA_OFF = 8'h55;
	localparam logic [7:0] FT_RLA_ON = 8'haa;
	localparam logic [7:0] FT_POR_OFF = 8'h66;
	localparam logic [7:0] FT_POR_ON = 8'hcc;
	localparam logic [7:0] FT_NOP_A = 8'h69;
	localparam logic [7:0] FT_NOP_B = 8'h96;
	localparam logic [7:0] FT_NOP_C = 8'h97;
	localparam logic [7:0] FT_CURRENT = 8'h9a;
	localparam logic [7:0] FT_LONG4 = 8'hbb;
	// Transfer types in sector count bits 7:3
	localparam logic [4:0] XT_PIO_DEF = 5'h00;
	localparam logic [4:0] XT_PIO_FC = 5'h01;
	localparam logic [4:0] XT_MDMA = 5'h04;
	localparam logic [4:0] XT_UDMA = 5'h08;
	localparam logic [2:0] MODE_NO_IORDY = 3'h1;
	// Register byte offsets
	localparam logic [7:0] ADDR_TASK = 8'h00;
	localparam logic [7:0] ADDR_CMD = 8'h04;
	localparam logic [7:0] ADDR_DATA = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_CFG = 8'h10;
	localparam logic [7:0] ADDR_CURRENT = 8'h14;
	// Data sector layout
	localparam logic [7:0] WORD_LAST = 8'hff;
	localparam logic [7:0] PWD_FIRST = 8'h01;
	localparam logic [7:0] PWD_LAST = 8'h10;
	localparam int ID_BIT = 0;
	localparam int LEVEL_BIT = 8;
	localparam logic [2:0] ATTEMPTS_INIT = 3'h5;
	// Supported current range, in units of 4 mA (arbitrary capability)
	localparam logic [7:0] CUR_MIN = 8'h01;
	localparam logic [7:0] CUR_MAX = 8'h3f;
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Card configuration, exactly one data word wide
	typedef struct packed {
		logic eightBit;
		logic writeCache;
		logic lookAhead;
		logic porDefaults;
		logic apmEn;
		logic [7:0] apmLevel;
		logic extPower;
		logic powerLevel1;
		logic longExtra;
		logic [7:0] currentCap;
		logic iordyOff;
		logic [2:0] pioMode;
		logic dmaUltra;
		logic [2:0] dmaMode;
	} cfg_t;
	localparam cfg_t CFG_DEFAULT = '{eightBit: 1'b0, writeCache: 1'b1, lookAhead: 1'b0,
		porDefaults: 1'b1, apmEn: 1'b0, apmLevel: 8'h00, extPower: 1'b0,
		powerLevel1: 1'b0, longExtra: 1'b1, currentCap: CUR_MAX, iordyOff: 1'b0,
		pioMode: 3'h0, dmaUltra: 1'b0, dmaMode: 3'h0};
	typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_FLUSH} state_t;
endpackage : ata_sec_pkg
